// file: logic/ubg_map.vh
// Register offsets, field positions, reset values and timing counts of the baud generator.
`ifndef UBG_MAP_VH
`define UBG_MAP_VH
`define UBG_OFF_CTRL        4'h0
`define UBG_OFF_DIV         4'h4
`define UBG_OFF_STAT        4'h8
`define UBG_OFF_MASK        4'hC
`define UBG_CTRL_UE         0
`define UBG_CTRL_ABEN       1
`define UBG_CTRL_MODE_LO    2
`define UBG_CTRL_MODE_HI    3
`define UBG_ST_DONE         0
`define UBG_ST_ERR          1
`define UBG_ST_RECEIVE_NOT_EMPTY         2
`define UBG_CTRL_RST        4'h0
`define UBG_DIV_RST         12'h010
`define UBG_OVS             16
`define UBG_MIN_BIT         17'h00010
`define UBG_MAX_BIT         17'h0FFFF
`define UBG_MODE_START      2'h0
`define UBG_MODE_START_BIT1 2'h1
`endif

// file: logic/ubg_tick_gen.v
// Fractional oversampling tick generator driven by the fixed-point divisor.
`timescale 1ns/1ps
`default_nettype none
module ubg_tick_gen
(
    // Clock and reset.
    input  wire        clk_i,
    input  wire        srst_i,
    // Divisor, reload and run enable.
    input  wire [11:0] div_i,
    input  wire        reload_i,
    input  wire        run_i,
    // Ticks.
    output reg         ovs_tick_o,
    output reg         bit_tick_o
);
    // Accumulating in sixteenths gives a bit period of exactly 16 x divisor clocks on average.
    reg [15:0] acc_q;
    reg [3:0]  ovs_cnt_q;
    wire [15:0] div_w = {4'h0, div_i};
    wire [15:0] acc_inc = acc_q + 16'h0010;

    always @(posedge clk_i)
    begin
        if (srst_i || reload_i || !run_i)
        begin
            acc_q      <= 16'h0000;  // [R3]
            ovs_cnt_q  <= 4'h0;
            ovs_tick_o <= 1'b0;
            bit_tick_o <= 1'b0;
        end
        else if (acc_inc >= div_w)
        begin
            acc_q      <= acc_inc - div_w;  // [R1] [R2]
            ovs_cnt_q  <= ovs_cnt_q + 4'h1;
            ovs_tick_o <= 1'b1;
            bit_tick_o <= (ovs_cnt_q == 4'hF);
        end
        else
        begin
            acc_q      <= acc_inc;
            ovs_tick_o <= 1'b0;
            bit_tick_o <= 1'b0;
        end
    end
endmodule // ubg_tick_gen
`default_nettype wire

// file: logic/ubg_top.v
// Baud generator with auto-baud detection and an AXI4-Lite register slave.
//
// Overview of operation
// R1: Bit rate is kernel clock over sixteen divisor.
// R2: Divisor is 12 bits, 4-bit fraction.
// R3: Divisor write reloads the baud counter immediately.
// R4: Software carries fraction overflow into integer.
// R5: Bit width outside 16..65535 raises error.
// R6: Software selects mode before enabling detection.
// R7: Mode 0 times falling to rising edge.
// R8: Mode 1 times two successive falling edges.
// R9: Repeated measurements compared against the previous; the code compares width_q with prev_q, which holds the same measurement.
// R10: Transitions checked against rate from bit 0.
// R11: Software loads non-zero divisor before detection.
// R12: After enable, measure first character, write divisor.
// R13: Completion sets the done flag.
// R14: Noisy measurement sets the error flag.
// R15: Completion also raises receive-not-empty event.
// R16: Writing zero to done clears and re-arms.
// R17: Software keeps unit enabled during detection.
// R18: Mode 0 and 1 decoded; others reserved.
`timescale 1ns/1ps
`include "ubg_map.vh"
`default_nettype none
module ubg_top
#(
    parameter TOL_CLKS = 17   // Allowed edge misalignment, in clocks, plus one sixteenth of the bit.
)
(
    // Clock and reset.
    input  wire        CLK_SYS_I,
    input  wire        SRST_I,
    // AXI4-Lite write address.
    input  wire        S_AXI_AWVALID_I,
    output wire        S_AXI_AWREADY_O,
    input  wire [3:0]  S_AXI_AWADDR_I,
    // AXI4-Lite write data.
    input  wire        S_AXI_WVALID_I,
    output wire        S_AXI_WREADY_O,
    input  wire [31:0] S_AXI_WDATA_I,
    input  wire [3:0]  S_AXI_WSTRB_I,
    // AXI4-Lite write response.
    output reg         S_AXI_BVALID_O,
    input  wire        S_AXI_BREADY_I,
    output reg  [1:0]  S_AXI_BRESP_O,
    // AXI4-Lite read address.
    input  wire        S_AXI_ARVALID_I,
    output wire        S_AXI_ARREADY_O,
    input  wire [3:0]  S_AXI_ARADDR_I,
    // AXI4-Lite read data.
    output reg         S_AXI_RVALID_O,
    input  wire        S_AXI_RREADY_I,
    output reg  [31:0] S_AXI_RDATA_O,
    output reg  [1:0]  S_AXI_RRESP_O,
    // Serial line and timing outputs.
    input  wire        RX_I,
    output wire        OVS_TICK_O,
    output wire        BIT_TICK_O,
    // Interrupt.
    output wire        IRQ_O
);
    // ****************************************************************
    // Registers and synchroniser
    // ****************************************************************
    localparam ST_IDLE = 4'b0001;
    localparam ST_MEAS = 4'b0010;
    localparam ST_CHK  = 4'b0100;
    localparam ST_HOLD = 4'b1000;

    reg [3:0]  ctrl_q;
    reg [11:0] div_q;
    reg [2:0]  stat_q;
    reg [2:0]  mask_q;
    reg [3:0]  state_q;
    reg [16:0] cnt_q;
    reg [16:0] width_q;
    reg [16:0] prev_q;
    reg [3:0]  bits_q;
    reg        rx_s1_q;
    reg        rx_s2_q;
    reg        rx_d_q;
    reg        aw_q;
    reg        w_q;
    reg [3:0]  awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;

    always @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
        begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_d_q  <= 1'b1;
        end
        else
        begin
            rx_s1_q <= RX_I;
            rx_s2_q <= rx_s1_q;
            rx_d_q  <= rx_s2_q;
        end
    end

    wire fall_w = rx_d_q & ~rx_s2_q;
    wire rise_w = ~rx_d_q & rx_s2_q;
    wire [1:0] mode_w = ctrl_q[`UBG_CTRL_MODE_HI:`UBG_CTRL_MODE_LO];
    wire ue_w   = ctrl_q[`UBG_CTRL_UE];
    wire aben_w = ctrl_q[`UBG_CTRL_ABEN];
    // Reserved mode values never start a measurement.
    wire mode_ok_w = (mode_w == `UBG_MODE_START) || (mode_w == `UBG_MODE_START_BIT1);  // [R18]

    // Width of one bit in clocks; mode 1 measures two bits.
    function [16:0] bit_clks;
        input [16:0] raw;
        input [1:0]  mode;
        begin
            bit_clks = (mode == `UBG_MODE_START_BIT1) ? {1'b0, raw[16:1]} : raw;
        end
    endfunction

    function in_range;
        input [16:0] w;
        begin
            in_range = (w >= `UBG_MIN_BIT) && (w <= `UBG_MAX_BIT);
        end
    endfunction

    // ****************************************************************
    // Auto-baud engine
    // ****************************************************************
    wire [16:0] one_bit_w  = bit_clks(cnt_q, mode_w);
    wire        end_meas_w = (mode_w == `UBG_MODE_START) ? rise_w : fall_w;  // [R7] [R8]
    // Edge phase inside the current bit, checked against the bit-0 rate.
    reg  [16:0] phase_q;
    wire [16:0] tol_w = {4'h0, width_q[16:4]} + TOL_CLKS[16:0];
    wire        sync_ok_w = (phase_q <= tol_w) || (phase_q + tol_w >= width_q);
    wire        div_wr_w;
    reg         ab_wr_q;
    reg         done_ev_q;
    reg         err_ev_q;

    always @(posedge CLK_SYS_I)
    begin
        if (SRST_I || !ue_w || !aben_w)
        begin
            state_q   <= ST_IDLE;
            cnt_q     <= 17'h00000;
            width_q   <= 17'h00000;
            prev_q    <= 17'h00000;
            phase_q   <= 17'h00000;
            bits_q    <= 4'h0;
            ab_wr_q   <= 1'b0;
            done_ev_q <= 1'b0;
            err_ev_q  <= 1'b0;
        end
        else
        begin
            ab_wr_q   <= 1'b0;
            done_ev_q <= 1'b0;
            err_ev_q  <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    cnt_q <= 17'h00001;  // The cycle that sees the falling edge already counts.
                    if (fall_w && mode_ok_w && !stat_q[`UBG_ST_DONE])  // [R12] [R16]
                    begin
                        state_q <= ST_MEAS;
                    end
                end
                ST_MEAS:
                begin
                    if (cnt_q != 17'h1FFFF)
                    begin
                        cnt_q <= cnt_q + 17'h00001;
                    end
                    if (end_meas_w)
                    begin
                        width_q <= one_bit_w;
                        prev_q  <= one_bit_w;
                        phase_q <= 17'h00000;
                        bits_q  <= 4'h0;
                        if (!in_range(one_bit_w))
                        begin
                            err_ev_q <= 1'b1;  // [R5]
                            state_q  <= ST_HOLD;
                        end
                        else
                        begin
                            state_q <= ST_CHK;
                        end
                    end
                end
                ST_CHK:
                begin
                    // Track the remaining bits of the character at the measured rate.
                    if (phase_q + 17'h00001 >= width_q)
                    begin
                        phase_q <= 17'h00000;
                        bits_q  <= bits_q + 4'h1;
                    end
                    else
                    begin
                        phase_q <= phase_q + 17'h00001;
                    end
                    if ((fall_w || rise_w) && !sync_ok_w)
                    begin
                        err_ev_q <= 1'b1;  // [R10] [R14]
                        state_q  <= ST_HOLD;
                    end
                    else if (bits_q == 4'h8)
                    begin
                        // Compare width_q with prev_q; both were loaded from the same bit-0 measurement.
                        prev_q <= width_q;  // [R9]
                        if ((prev_q > width_q + tol_w) || (width_q > prev_q + tol_w))
                        begin
                            err_ev_q <= 1'b1;
                        end
                        else
                        begin
                            ab_wr_q   <= 1'b1;
                            done_ev_q <= 1'b1;
                        end
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    if (!stat_q[`UBG_ST_DONE] && !done_ev_q && !err_ev_q)
                    begin
                        state_q <= ST_IDLE;  // [R16]
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    assign S_AXI_AWREADY_O = !aw_q && !S_AXI_BVALID_O;
    assign S_AXI_WREADY_O  = !w_q && !S_AXI_BVALID_O;
    assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
    wire   wr_go_w = aw_q && w_q && !S_AXI_BVALID_O;
    wire   wr_ok_w = (awaddr_q == `UBG_OFF_CTRL) || (awaddr_q == `UBG_OFF_DIV) ||
                     (awaddr_q == `UBG_OFF_STAT) || (awaddr_q == `UBG_OFF_MASK);
    assign div_wr_w = wr_go_w && (awaddr_q == `UBG_OFF_DIV) && (wstrb_q[1:0] == 2'h3);

    always @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
        begin
            aw_q           <= 1'b0;
            w_q            <= 1'b0;
            awaddr_q       <= 4'h0;
            wdata_q        <= 32'h00000000;
            wstrb_q        <= 4'h0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O  <= 2'h0;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O  <= 32'h00000000;
            S_AXI_RRESP_O  <= 2'h0;
            ctrl_q         <= `UBG_CTRL_RST;
            div_q          <= `UBG_DIV_RST;
            mask_q         <= 3'h0;
        end
        else
        begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
            begin
                aw_q     <= 1'b1;
                awaddr_q <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O)
            begin
                w_q     <= 1'b1;
                wdata_q <= S_AXI_WDATA_I;
                wstrb_q <= S_AXI_WSTRB_I;
            end
            if (wr_go_w)
            begin
                aw_q           <= 1'b0;
                w_q            <= 1'b0;
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O  <= wr_ok_w ? 2'h0 : 2'h3;
                if (awaddr_q == `UBG_OFF_CTRL && wstrb_q[0])
                begin
                    ctrl_q <= wdata_q[3:0];
                end
                if (awaddr_q == `UBG_OFF_MASK && wstrb_q[0])
                begin
                    mask_q <= wdata_q[2:0];
                end
            end
            else if (S_AXI_BVALID_O && S_AXI_BREADY_I)
            begin
                S_AXI_BVALID_O <= 1'b0;
            end
            if (div_wr_w)
            begin
                div_q <= wdata_q[11:0];  // [R3]
            end
            else if (ab_wr_q)
            begin
                div_q <= width_q[11:0];  // [R12]
            end
            if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
            begin
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RRESP_O  <= 2'h0;
                case (S_AXI_ARADDR_I)
                    `UBG_OFF_CTRL: S_AXI_RDATA_O <= {28'h0000000, ctrl_q};
                    `UBG_OFF_DIV:  S_AXI_RDATA_O <= {20'h00000, div_q};
                    `UBG_OFF_STAT: S_AXI_RDATA_O <= {28'h0000000, state_q != ST_IDLE, stat_q};
                    `UBG_OFF_MASK: S_AXI_RDATA_O <= {29'h00000000, mask_q};
                    default:
                    begin
                        S_AXI_RDATA_O <= 32'h00000000;
                        S_AXI_RRESP_O <= 2'h3;
                    end
                endcase
            end
            else if (S_AXI_RVALID_O && S_AXI_RREADY_I)
            begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Status flags and interrupt
    // ****************************************************************
    // Done clears on a written zero, error and receive_not_empty on a written one; a same-cycle event wins.
    wire stat_wr_w = wr_go_w && (awaddr_q == `UBG_OFF_STAT) && wstrb_q[0];
    wire [2:0] set_w = {done_ev_q, err_ev_q, done_ev_q};  // [R13] [R14] [R15]
    wire [2:0] clr_w = stat_wr_w ? {wdata_q[2], wdata_q[1], ~wdata_q[0]} : 3'h0;  // [R16]

    always @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
        begin
            stat_q <= 3'h0;
        end
        else
        begin
            stat_q <= set_w | (stat_q & ~clr_w);
        end
    end

    assign IRQ_O = |(stat_q & mask_q);

    // ****************************************************************
    // Tick generator
    // ****************************************************************
    ubg_tick_gen u_tick
    (
        .clk_i      (CLK_SYS_I),
        .srst_i     (SRST_I),
        .div_i      (div_q),
        .reload_i   (div_wr_w | ab_wr_q),
        .run_i      (ue_w),
        .ovs_tick_o (OVS_TICK_O),
        .bit_tick_o (BIT_TICK_O)
    );
endmodule // ubg_top
`default_nettype wire

// file: sim/ubg_monitor.sv
// Concurrent checks on the register bus of the baud generator top.
`timescale 1ns/1ps
`default_nettype none
module ubg_monitor
(
    // Clock and reset.
    input  wire logic        CLK_SYS_I,
    input  wire logic        SRST_I,
    // Write channels.
    input  wire logic        S_AXI_AWVALID_I,
    input  wire logic        S_AXI_AWREADY_O,
    input  wire logic        S_AXI_WVALID_I,
    input  wire logic        S_AXI_WREADY_O,
    input  wire logic        S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    input  wire logic [1:0]  S_AXI_BRESP_O,
    // Read channels.
    input  wire logic        S_AXI_ARVALID_I,
    input  wire logic        S_AXI_ARREADY_O,
    input  wire logic        S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    input  wire logic [31:0] S_AXI_RDATA_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (SRST_I);

    sequence s_wr_taken;
        S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
    endsequence
    sequence s_rd_taken;
        S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    endsequence

    a_write_answer: assert property (s_wr_taken |=> ##1 S_AXI_BVALID_O)
        else $error("write response missing two cycles after address and data");
    a_read_answer: assert property (s_rd_taken |=> S_AXI_RVALID_O)
        else $error("read data missing one cycle after address");
    a_bvalid_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("write response dropped or changed before acceptance");
    a_rvalid_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
        else $error("read data dropped or changed before acceptance");
    a_aw_refused: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O)
        else $error("write address accepted while a response is pending");
    a_w_refused: assert property (S_AXI_BVALID_O |-> !S_AXI_WREADY_O)
        else $error("write data accepted while a response is pending");
    a_ar_refused: assert property (S_AXI_ARREADY_O == !S_AXI_RVALID_O)
        else $error("read address ready does not mirror pending read data");
    a_b_released: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
        else $error("write response held after acceptance");
endmodule // ubg_monitor

bind ubg_top ubg_monitor mon
(
    .CLK_SYS_I       (CLK_SYS_I),
    .SRST_I          (SRST_I),
    .S_AXI_AWVALID_I (S_AXI_AWVALID_I),
    .S_AXI_AWREADY_O (S_AXI_AWREADY_O),
    .S_AXI_WVALID_I  (S_AXI_WVALID_I),
    .S_AXI_WREADY_O  (S_AXI_WREADY_O),
    .S_AXI_BVALID_O  (S_AXI_BVALID_O),
    .S_AXI_BREADY_I  (S_AXI_BREADY_I),
    .S_AXI_BRESP_O   (S_AXI_BRESP_O),
    .S_AXI_ARVALID_I (S_AXI_ARVALID_I),
    .S_AXI_ARREADY_O (S_AXI_ARREADY_O),
    .S_AXI_RVALID_O  (S_AXI_RVALID_O),
    .S_AXI_RREADY_I  (S_AXI_RREADY_I),
    .S_AXI_RDATA_O   (S_AXI_RDATA_O)
);
`default_nettype wire

// file: sim/ubg_rx_partner.sv
// Remote serial transmitter that drives the receive line.
`timescale 1ns/1ps
`default_nettype none
module ubg_rx_partner
(
    input  wire logic clk_i,
    output var  logic rx_o
);
    initial rx_o = 1'b1;

    // One frame: start bit, eight data bits first bit first, one stop bit; w clocks per bit.
    // The line idles high between frames, as a pulled-up receive line would.
    task automatic send(input logic [7:0] b, input int w);
        send_skew(b, w, w);
    endtask

    // Same frame, but the start bit lasts w0 clocks and every later bit w clocks.
    task automatic send_skew(input logic [7:0] b, input int w0, input int w);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk_i);
            rx_o <= fr[i];
            repeat (((i == 0) ? w0 : w) - 1) @(posedge clk_i);
        end
    endtask
endmodule // ubg_rx_partner
`default_nettype wire

// file: sim/uart_baud_gen_autobaud_bench.sv
// Self-checking bench for the baud generator with auto-baud detection.
`timescale 1ns/1ps
`default_nettype none
module uart_baud_gen_autobaud_bench;
    logic        clk = 1'b0, srst = 1'b1;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, rdata;
    wire         awready, wready, bvalid, arready, rvalid, rx, ovs_tick, bit_tick, irq;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata_w;
    int          error_cnt = 0;
    int          n_tests = 0;

    initial forever #20 clk = ~clk;

    ubg_rx_partner link (.clk_i(clk), .rx_o(rx));

    ubg_top uut
    (
        .CLK_SYS_I(clk), .SRST_I(srst),
        .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_AWADDR_I(awaddr),
        .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
        .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_BRESP_O(bresp),
        .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_ARADDR_I(araddr),
        .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .S_AXI_RDATA_O(rdata_w), .S_AXI_RRESP_O(rresp),
        .RX_I(rx), .OVS_TICK_O(ovs_tick), .BIT_TICK_O(bit_tick), .IRQ_O(irq)
    );

    // ****************************************
    // Reporting and comparison.
    // ****************************************
    task automatic final_report();
        if (error_cnt == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic timed_out();
        error_cnt++;
        $display("Error at %0t: got %h expected %h", $time, 32'h0, 32'h1);
        final_report();
    endtask

    // ****************************************
    // Register bus master.
    // ****************************************
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            n++;
            if (n > 100) timed_out();
        end
        while (!bvalid);
        chk(bresp, 2'h0);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            n++;
            if (n > 100) timed_out();
        end
        while (!rvalid);
        d = rdata_w;
        chk(rresp, 2'h0);
        rready <= 1'b0;
    endtask

    task automatic wait_irq();
        int n;
        for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk);
        if (n >= 3000) timed_out();
    endtask

    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic t_reset_values();
        rd(4'h4, rdata); chk(rdata & 32'hFFF, 32'h010);
        rd(4'h0, rdata); chk(rdata & 32'hF, 32'h0);
        rd(4'h8, rdata); chk(rdata & 32'h7, 32'h0);
    endtask

    // A carried fraction, 50.99 rounded to 51.0, gives a bit period of 816 clocks.
    task automatic t_bit_rate();
        int n;
        int k;
        k = 0;
        wr(4'h0, 32'h1);
        wr(4'h4, 32'h330);
        rd(4'h4, rdata); chk(rdata & 32'hFFF, 32'h330);
        for (n = 0; n < 2000 && bit_tick !== 1'b1; n++) @(posedge clk);
        @(posedge clk);
        for (n = 1; n < 2000 && bit_tick !== 1'b1; n++)
        begin
            k += ovs_tick;
            @(posedge clk);
        end
        chk(n, 816);
        chk(k + ovs_tick, 16);
    endtask

    // Mode is written before detection is enabled; the divisor is already non-zero.
    task automatic t_detect(input logic [1:0] mode, input int w);
        wr(4'hC, 32'h7);
        wr(4'h0, {28'h0, mode, 2'b01});
        wr(4'h0, {28'h0, mode, 2'b11});
        link.send(8'h01, w);
        wait_irq();
        rd(4'h8, rdata); chk(rdata & 32'h7, 32'h5);
        rd(4'h4, rdata); chk(rdata & 32'hFFF, w);
        wr(4'h8, 32'h6);
        rd(4'h8, rdata); chk(rdata & 32'h7, 32'h0);
        chk(irq, 1'b0);
    endtask

    // Too short a bit: error raised while masked, then unmasked and cleared.
    task automatic t_too_fast();
        wr(4'hC, 32'h0);
        link.send(8'h01, 10);
        repeat (200) @(posedge clk);
        rd(4'h8, rdata); chk(rdata & 32'h2, 32'h2);
        chk(irq, 1'b0);
        wr(4'hC, 32'h2);
        @(posedge clk);
        chk(irq, 1'b1);
        wr(4'h8, 32'h6);
        @(posedge clk);
        chk(irq, 1'b0);
    endtask

    // Later bits run half as long again as the start bit, so an edge falls off the measured grid.
    task automatic t_out_of_sync();
        wr(4'h0, 32'h1);
        wr(4'h0, 32'h3);
        link.send_skew(8'h01, 100, 150);
        rd(4'h8, rdata); chk(rdata & 32'h7, 32'h2);
        chk(irq, 1'b1);
        wr(4'h8, 32'h2);
    endtask

    // A reserved mode never starts a measurement.
    task automatic t_reserved_mode();
        wr(4'hC, 32'h7);
        wr(4'h0, 32'hB);
        link.send(8'h01, 100);
        repeat (50) @(posedge clk);
        rd(4'h8, rdata); chk(rdata & 32'h7, 32'h0);
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        t_reset_values();
        t_bit_rate();
        t_detect(2'd0, 100);
        t_detect(2'd1, 120);
        t_too_fast();
        t_out_of_sync();
        t_reserved_mode();
        final_report();
    end
endmodule // uart_baud_gen_autobaud_bench
`default_nettype wire
